// file: rtl/adc_protect_params.svh
// Function
// R1: continuous scan mode: start-channel result held, pause set while scan-done pending; the code does this only while scan-done is enabled.
// R2: reader clears scan-done, then held result is stored and scanning resumes.
// R3: other modes: any result held, pause set while conversion-done pending.
// R4: exactly two interrupt sources, conversion-done and scan-done.
// R5: conversion-done request raised after every stored conversion when enabled.
// R6: scan-done request raised only after the end channel when enabled.
// R7: both enables set and end channel done: both flags set.
// R8: second control/status register mirrors bits 7 to 4 of the first.
// R9: each request drives its own DMA request line.
// R10: DMA acknowledge clears only the flag of its own request.
// R11: reader should fetch latest result by DMA on conversion-done.
// R12: converter halts while paused, restarts when guarding flag clears.
// R13: 32 per-channel result registers, written by hardware, readable anytime.
`ifndef ADC_PROTECT_PARAMS_SVH
`define ADC_PROTECT_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFS_CS1 12'h000
`define OFS_CS2 12'h004
`define OFS_STATUS 12'h008
`define OFS_MASK 12'h00C
`define OFS_CHSEL 12'h010
`define OFS_LATEST 12'h014
`define CHAN_AREA_HI 5'h01

// ==========================================================
// field positions
`define CS1_CONV_FLAG 7
`define CS1_CONV_IE 6
`define CS1_PAUSE 5
`define CS1_CONT 4
`define CS2_SCAN_FLAG 3
`define CS2_SCAN_IE 2
`define STAT_CONV 0
`define STAT_SCAN 1
`define CHSEL_START_LSB 0
`define CHSEL_END_LSB 8

// ==========================================================
// reset values
`define RST_CHAN 5'h00
`define RST_MASK 2'h0
`define RST_DATA 10'h000

`endif

// file: rtl/adc_protect_pkg.sv
package adc_protect_pkg;
    // RUN and HOLD differ in one bit
    typedef enum logic [0:0] {
        RUN = 1'b0,
        HOLD = 1'b1
    } prot_t;
endpackage

// file: rtl/adc_result_protect_irq.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_protect_params.svh"

module adc_result_protect_irq (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // converter core
    input wire logic RES_VALID,
    input wire logic [4:0] RES_CHAN,
    input wire logic [9:0] RES_DATA,
    output logic PAUSE,
    // dma controller
    input wire logic DMA_ACK_CONV,
    input wire logic DMA_ACK_SCAN,
    output logic DMA_REQ_CONV,
    output logic DMA_REQ_SCAN,
    // interrupt
    output logic IRQ
);

    // ==========================================================
    // state
    logic [9:0] chan_result [0:31];
    logic [9:0] latest;
    logic conv_flag;
    logic scan_flag;
    logic conv_ie;
    logic scan_ie;
    logic cont_mode;
    logic [4:0] start_chan;
    logic [4:0] end_chan;
    logic [1:0] irq_mask;
    adc_protect_pkg::prot_t prot_state;
    logic [4:0] held_chan;
    logic [9:0] held_data;

    // ==========================================================
    // bus address phase capture
    logic addr_ok;
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] next_rdata;

    assign addr_ok = HSEL && HREADY && HTRANS[1];

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wr_en <= 1'b0;
            wr_addr <= 12'h000;
        end
        else
        begin
            wr_en <= addr_ok && HWRITE;
            wr_addr <= HADDR[11:0];
        end
    end

    // zero wait states; every transfer answers OKAY
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // ==========================================================
    // write decode
    logic wr_cs1;
    logic wr_cs2;
    logic wr_stat;
    logic wr_mask;
    logic wr_sel;

    assign wr_cs1 = wr_en && (wr_addr == `OFS_CS1);
    assign wr_cs2 = wr_en && (wr_addr == `OFS_CS2);
    assign wr_stat = wr_en && (wr_addr == `OFS_STATUS);
    assign wr_mask = wr_en && (wr_addr == `OFS_MASK);
    assign wr_sel = wr_en && (wr_addr == `OFS_CHSEL);

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            conv_ie <= 1'b0;
            cont_mode <= 1'b0;
            scan_ie <= 1'b0;
            irq_mask <= `RST_MASK;
            start_chan <= `RST_CHAN;
            end_chan <= `RST_CHAN;
        end
        else
        begin
            if (wr_cs1)
            begin
                conv_ie <= HWDATA[`CS1_CONV_IE];
                cont_mode <= HWDATA[`CS1_CONT];
            end
            if (wr_cs2)
                scan_ie <= HWDATA[`CS2_SCAN_IE];
            if (wr_mask)
                irq_mask <= HWDATA[1:0];
            if (wr_sel)
            begin
                start_chan <= HWDATA[`CHSEL_START_LSB +: 5];
                end_chan <= HWDATA[`CHSEL_END_LSB +: 5];
            end
        end
    end

    // ==========================================================
    // result protection
    logic scan_protect;
    logic guard_flag;
    logic hold_now;
    logic release_now;
    logic store_now;
    logic [4:0] store_chan;
    logic [9:0] store_data;

    // continuous scan with scan-done enabled guards the whole scan, otherwise every single result
    assign scan_protect = cont_mode && scan_ie;
    assign guard_flag = scan_protect ? scan_flag : conv_flag;
    assign hold_now = RES_VALID && (prot_state == adc_protect_pkg::RUN) &&
        (scan_protect ? (scan_flag && (RES_CHAN == start_chan)) : conv_flag); // [R1] [R3]
    assign release_now = (prot_state == adc_protect_pkg::HOLD) && !guard_flag; // [R2] [R12]
    assign store_now = release_now ||
        (RES_VALID && (prot_state == adc_protect_pkg::RUN) && !hold_now);
    assign store_chan = release_now ? held_chan : RES_CHAN;
    assign store_data = release_now ? held_data : RES_DATA;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            prot_state <= adc_protect_pkg::RUN;
            held_chan <= `RST_CHAN;
            held_data <= `RST_DATA;
        end
        else if (hold_now)
        begin
            prot_state <= adc_protect_pkg::HOLD; // [R1] [R3]
            held_chan <= RES_CHAN;
            held_data <= RES_DATA;
        end
        else if (release_now)
            prot_state <= adc_protect_pkg::RUN; // [R2] [R12]
    end

    // the core must not deliver a result while paused; such a result is dropped
    assign PAUSE = prot_state[0]; // [R12]

    // ==========================================================
    // result storage
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            latest <= `RST_DATA;
        else if (store_now)
            latest <= store_data;
    end

    // no reset: contents are undefined until a channel is converted
    always_ff @(posedge CLK)
    begin
        if (store_now)
            chan_result[store_chan] <= store_data; // [R13]
    end

    // ==========================================================
    // request flags, a set in the same cycle as a clear wins
    logic set_conv;
    logic set_scan;
    logic clr_conv;
    logic clr_scan;

    assign set_conv = store_now && conv_ie; // [R5] [R7]
    assign set_scan = store_now && scan_ie && (store_chan == end_chan); // [R6] [R7]
    assign clr_conv = DMA_ACK_CONV || (wr_cs1 && HWDATA[`CS1_CONV_FLAG]) ||
        (wr_stat && HWDATA[`STAT_CONV]); // [R10]
    assign clr_scan = DMA_ACK_SCAN || (wr_cs2 && HWDATA[`CS2_SCAN_FLAG]) ||
        (wr_stat && HWDATA[`STAT_SCAN]); // [R10]

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            conv_flag <= 1'b0;
            scan_flag <= 1'b0;
        end
        else
        begin
            conv_flag <= set_conv || (conv_flag && !clr_conv); // [R4] [R5]
            scan_flag <= set_scan || (scan_flag && !clr_scan); // [R4] [R6]
        end
    end

    // separate lines; dropped while the acknowledge is seen to avoid a repeat
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            DMA_REQ_CONV <= 1'b0;
            DMA_REQ_SCAN <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            DMA_REQ_CONV <= conv_flag && !DMA_ACK_CONV; // [R9] [R11]
            DMA_REQ_SCAN <= scan_flag && !DMA_ACK_SCAN; // [R9]
            IRQ <= |({scan_flag, conv_flag} & irq_mask);
        end
    end

    // ==========================================================
    // read path
    logic [7:0] cs1_bits;

    assign cs1_bits = {conv_flag, conv_ie, PAUSE, cont_mode, 4'h0};

    always_comb
    begin
        next_rdata = 32'h00000000;
        if (HADDR[11:7] == `CHAN_AREA_HI)
            next_rdata = {22'h0, chan_result[HADDR[6:2]]}; // [R13]
        else if (HADDR[11:0] == `OFS_CS1)
            next_rdata = {24'h000000, cs1_bits};
        else if (HADDR[11:0] == `OFS_CS2)
            next_rdata = {24'h000000, cs1_bits[7:4], scan_flag, scan_ie, 2'h0}; // [R8]
        else if (HADDR[11:0] == `OFS_STATUS)
            next_rdata = {30'h0, scan_flag, conv_flag};
        else if (HADDR[11:0] == `OFS_MASK)
            next_rdata = {30'h0, irq_mask};
        else if (HADDR[11:0] == `OFS_CHSEL)
            next_rdata = {19'h0, end_chan, 3'h0, start_chan};
        else if (HADDR[11:0] == `OFS_LATEST)
            next_rdata = {22'h0, latest};
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            HRDATA <= 32'h00000000;
        else if (addr_ok && !HWRITE)
            HRDATA <= next_rdata;
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    a_hold_sets_pause: assert property (hold_now |=> PAUSE && $stable(latest)) // [R1]
        else $error("held result did not pause");
    a_scan_guard: assert property (scan_protect && RES_VALID && !PAUSE && scan_flag
        && RES_CHAN == start_chan |=> PAUSE) // [R1]
        else $error("start channel not held during pending scan-done");
    a_release_store: assert property (release_now |=> !PAUSE
        && latest == $past(held_data)) // [R2]
        else $error("release did not store held result");
    a_single_guard: assert property (!scan_protect && conv_flag && RES_VALID && !PAUSE
        |=> PAUSE) // [R3]
        else $error("result not held during pending conversion-done");
    a_pause_blocks: assert property (PAUSE && guard_flag |=> $stable(latest)) // [R12]
        else $error("latest result changed while paused");
    a_conv_set: assert property (store_now && conv_ie |=> conv_flag) // [R5]
        else $error("conversion-done not raised");
    a_scan_end: assert property ($rose(scan_flag) |-> $past(store_now)
        && $past(store_chan) == $past(end_chan)) // [R6]
        else $error("scan-done raised off the end channel");
    a_both_flags: assert property (store_now && conv_ie && scan_ie
        && store_chan == end_chan |=> conv_flag && scan_flag) // [R7]
        else $error("both flags not set at end channel");
    a_cs2_mirror: assert property (addr_ok && !HWRITE && HADDR[11:0] == `OFS_CS2
        |=> HRDATA[7:4] == {$past(conv_flag), $past(conv_ie), $past(PAUSE),
        $past(cont_mode)}) // [R8]
        else $error("second register mirror wrong");
    a_dma_req: assert property (conv_flag && !DMA_ACK_CONV |=> DMA_REQ_CONV) // [R9]
        else $error("dma conversion request missing");
    a_dma_clear: assert property (DMA_ACK_CONV && !set_conv && !clr_scan && !set_scan
        |=> !conv_flag && $stable(scan_flag)) // [R10]
        else $error("dma acknowledge clear not independent");
    a_chan_store: assert property (store_now
        |=> chan_result[$past(store_chan)] == $past(store_data)) // [R13]
        else $error("channel result not stored");

endmodule

`default_nettype wire

// file: verif/adc_dma_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// dma reader, acks a request lag cycles after it is first seen
module adc_dma_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic en,
    input wire logic [3:0] lag,
    // request line
    input wire logic req,
    output logic ack
);
    logic [3:0] cnt;
    // one ack per request: count restarts after the ack edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 4'h0;
            ack <= 1'b0;
        end
        else
        begin
            ack <= 1'b0;
            if (ack || !req || !en)
                cnt <= 4'h0;
            else if (cnt == lag)
                ack <= 1'b1;
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: verif/adc_result_protect_irq_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_result_protect_irq_bench;
    logic CLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP, RES_VALID, PAUSE, IRQ;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [4:0] RES_CHAN;
    logic [9:0] RES_DATA;
    logic DMA_ACK_CONV, DMA_ACK_SCAN, DMA_REQ_CONV, DMA_REQ_SCAN, en_conv, en_scan;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    adc_result_protect_irq u_adc_result_protect_irq (.CLK(CLK), .RESET(RESET),
        .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .RES_VALID(RES_VALID), .RES_CHAN(RES_CHAN), .RES_DATA(RES_DATA),
        .PAUSE(PAUSE), .DMA_ACK_CONV(DMA_ACK_CONV), .DMA_ACK_SCAN(DMA_ACK_SCAN),
        .DMA_REQ_CONV(DMA_REQ_CONV), .DMA_REQ_SCAN(DMA_REQ_SCAN), .IRQ(IRQ));
    // prompt reader on conversion-done, slow one on scan-done
    adc_dma_model u_dma_conv (.clk(CLK), .rst(RESET), .en(en_conv), .lag(4'h0),
        .req(DMA_REQ_CONV), .ack(DMA_ACK_CONV));
    adc_dma_model u_dma_scan (.clk(CLK), .rst(RESET), .en(en_scan), .lag(4'h5),
        .req(DMA_REQ_SCAN), .ack(DMA_ACK_SCAN));
    // ====
    // clock, watchdog, bus and check tasks
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge CLK);
        HSEL <= 1'b1;
        HADDR <= {20'h00000, a};
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk($sformatf("reg %h", a), q, e);
    endtask
    task automatic res(input logic [4:0] c, input logic [9:0] d);
        @(posedge CLK);
        RES_VALID <= 1'b1;
        RES_CHAN <= c;
        RES_DATA <= d;
        @(posedge CLK);
        RES_VALID <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // ====
    // scenarios
    task automatic t_reset();
        tick(1);
        chk("PAUSE", 32'(PAUSE), 32'h0);
        chk("HRESP", 32'(HRESP), 32'h0);
        chk("HREADYOUT", 32'(HREADYOUT), 32'h1);
        chk("IRQ", 32'(IRQ), 32'h0);
        chk("DMA_REQ_CONV", 32'(DMA_REQ_CONV), 32'h0);
        chk("DMA_REQ_SCAN", 32'(DMA_REQ_SCAN), 32'h0);
        rc(12'h008, 32'h0);
        wr(12'h040, 32'hFFFFFFFF);
        rc(12'h040, 32'h0);
    endtask
    task automatic t_conv();
        wr(12'h000, 32'h40);
        wr(12'h00C, 32'h3);
        res(5'h03, 10'h155);
        tick(2);
        chk("DMA_REQ_CONV", 32'(DMA_REQ_CONV), 32'h1);
        chk("IRQ", 32'(IRQ), 32'h1);
        rc(12'h014, 32'h155);
        rc(12'h08C, 32'h155);
        res(5'h09, 10'h2AA);
        tick(1);
        chk("PAUSE", 32'(PAUSE), 32'h1);
        rc(12'h014, 32'h155);
        wr(12'h008, 32'h1);
        tick(2);
        chk("PAUSE", 32'(PAUSE), 32'h0);
        rc(12'h014, 32'h2AA);
        rc(12'h0A4, 32'h2AA);
        @(posedge CLK);
        en_conv <= 1'b1;
        tick(6);
        chk("DMA_REQ_CONV", 32'(DMA_REQ_CONV), 32'h0);
        rc(12'h008, 32'h0);
        en_conv <= 1'b0;
    endtask
    task automatic t_both();
        wr(12'h004, 32'h04);
        wr(12'h010, 32'h0704);
        res(5'h07, 10'h3FF);
        tick(2);
        chk("DMA_REQ_SCAN", 32'(DMA_REQ_SCAN), 32'h1);
        rc(12'h008, 32'h3);
        rc(12'h004, 32'hCC);
        en_scan <= 1'b1;
        tick(10);
        en_scan <= 1'b0;
        chk("DMA_REQ_SCAN", 32'(DMA_REQ_SCAN), 32'h0);
        chk("DMA_REQ_CONV", 32'(DMA_REQ_CONV), 32'h1);
        wr(12'h008, 32'h1);
        res(5'h05, 10'h0AA);
        tick(2);
        rc(12'h008, 32'h1);
        wr(12'h008, 32'h1);
    endtask
    task automatic t_scan();
        wr(12'h000, 32'h10);
        for (int i = 4; i < 8; i++)
            res(5'(i), 10'h100 + 10'(i));
        tick(2);
        rc(12'h008, 32'h2);
        rc(12'h004, 32'h1C);
        chk("IRQ", 32'(IRQ), 32'h1);
        wr(12'h00C, 32'h1);
        tick(2);
        chk("IRQ", 32'(IRQ), 32'h0);
        res(5'h04, 10'h044);
        tick(1);
        chk("PAUSE", 32'(PAUSE), 32'h1);
        rc(12'h090, 32'h104);
        en_scan <= 1'b1;
        tick(12);
        chk("PAUSE", 32'(PAUSE), 32'h0);
        rc(12'h090, 32'h044);
        rc(12'h014, 32'h044);
    endtask
    // software clears: scan flag through the second register, then conversion
    // guard in continuous mode without scan enable, cleared through the first
    task automatic t_soft();
        en_scan <= 1'b0;
        wr(12'h000, 32'hD0);
        res(5'h07, 10'h077);
        res(5'h04, 10'h1C4);
        tick(1);
        chk("PAUSE", 32'(PAUSE), 32'h1);
        rc(12'h09C, 32'h077);
        wr(12'h004, 32'h0C);
        tick(2);
        chk("PAUSE", 32'(PAUSE), 32'h0);
        rc(12'h090, 32'h1C4);
        rc(12'h008, 32'h1);
        chk("IRQ", 32'(IRQ), 32'h1);
        wr(12'h004, 32'h00);
        res(5'h02, 10'h222);
        tick(1);
        chk("PAUSE", 32'(PAUSE), 32'h1);
        rc(12'h014, 32'h1C4);
        wr(12'h000, 32'hD0);
        tick(2);
        chk("PAUSE", 32'(PAUSE), 32'h0);
        rc(12'h088, 32'h222);
        rc(12'h000, 32'hD0);
    endtask
    initial
    begin
        RESET = 1'b1;
        {HSEL, HWRITE, RES_VALID, en_conv, en_scan} = 5'h00;
        {HADDR, HWDATA} = 64'h0;
        HTRANS = 2'h0;
        RES_CHAN = 5'h00;
        RES_DATA = 10'h000;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        t_reset();
        t_conv();
        t_both();
        t_scan();
        t_soft();
        conclude();
    end
endmodule
`default_nettype wire
